/* File: pkg/bfs_params.svh */
`ifndef BFS_PARAMS_SVH
`define BFS_PARAMS_SVH

// Time base.
`define BFS_CLK_MHZ          50

// Qualification and blanking times in nanoseconds.
`define BFS_T_SPIKE_NS       30000
`define BFS_T_OVP_HIGH_NS    150000
`define BFS_T_BLANK_NS       20000000
`define BFS_T_UNDERVOLT_NS   10030000
`define BFS_T_EXT_BLANK_NS   1000000
`define BFS_T_SOFT_NS        20000000

// Least time rounded up to whole cycles.
`define BFS_CYC(ns)          (((ns) * `BFS_CLK_MHZ + 999) / 1000)

// Register offsets.
`define BFS_REG_STATUS       8'h00
`define BFS_REG_MASK         8'h04
`define BFS_REG_STATE        8'h08

// Status and mask bit positions.
`define BFS_EV_BURST_IN      0
`define BFS_EV_BURST_OUT     1
`define BFS_EV_SOFT_DONE     2
`define BFS_EV_FAULT_LSB     3
`define BFS_EV_WIDTH         9

// Reset values.
`define BFS_STATUS_RST       9'h000
`define BFS_MASK_RST         9'h000

`endif

/* File: pkg/bfs_pkg.sv */
`default_nettype none

package bfs_pkg;

    typedef enum logic [2:0] {
        ST_CHARGE,
        ST_SOFT,
        ST_NORMAL,
        ST_BURST,
        ST_RESTART
    } bfs_state_t;

    // Qualifier slots; the first six are protection faults.
    typedef enum int {
        Q_OVP_SOFT  = 0,
        Q_OVP_HIGH  = 1,
        Q_OVERTEMP  = 2,
        Q_OVERLOAD  = 3,
        Q_UNDERVOLT = 4,
        Q_EXT       = 5,
        Q_FB_HIGH   = 6,
        Q_BURST     = 7,
        Q_EXT_WIN   = 8,
        Q_SOFT      = 9
    } bfs_qual_t;

endpackage : bfs_pkg

`default_nettype wire

/* File: pkg/bfs_qual_if.sv */
`default_nettype none

interface bfs_qual_if;
    logic cond;
    logic done;

    modport owner (output cond, input done);
    modport timer (input cond, output done);
endinterface : bfs_qual_if

`default_nettype wire

/* File: src/bfs_qualifier.sv */
`default_nettype none

// Persistence timer: done rises once cond has held for LIMIT cycles.
module bfs_qualifier
    import bfs_pkg::*;
#(
    parameter int           W     = 21,
    parameter logic [W-1:0] LIMIT = 21'd1500
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Condition and result.
    bfs_qual_if.timer q
);

    logic [W-1:0] cnt;

    if (LIMIT == '0) begin : g_bad_limit
        $error("bfs_qualifier: LIMIT must be at least one cycle");
    end

    // Any drop of the condition starts the measurement over.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= '0;
        end else if (!q.cond) begin
            cnt <= '0;
        end else if (cnt != LIMIT) begin
            cnt <= cnt + W'(1);
        end
    end

    assign q.done = (cnt == LIMIT);

endmodule : bfs_qualifier

`default_nettype wire

/* File: src/bfs_sequencer.sv */
// The address-and-strobe port and the register offsets were chosen for this implementation.
`default_nettype none
`include "bfs_params.svh"

// Summary of operation
// RULE_01: Burst blanking counter stays zero normally, counts while feedback below 1.35 V.
// RULE_02: Burst mode entered only after 20 ms with feedback still below 1.35 V.
// RULE_03: Burst entry sets burst flag and switches internal bias off.
// RULE_04: Startup cell stays disabled throughout burst mode.
// RULE_05: In burst, feedback above 3.5 V re-enables bias and switching.
// RULE_06: Switching in burst uses the reduced 0.34 V current limit.
// RULE_07: In burst, feedback down to 3.0 V switches bias off again.
// RULE_08: Feedback above 4.0 V leaves burst and restores full current limit.
// RULE_09: Supply above 20.5 V with feedback above 4 V in soft start, 30 us.
// RULE_10: Supply above 25.5 V for 150 us restarts; inactive during burst.
// RULE_11: Over-temperature held 30 us enters auto restart.
// RULE_12: Overload: feedback high 20 ms, then blanking pin above 4.0 V 30 us.
// RULE_13: Supply below 10.5 V for 10 ms plus 30 us enters auto restart.
// RULE_14: Blanking pin below 0.33 V for 30 us requests auto restart.
// RULE_15: Only overload uses extended blanking; other faults restart directly.
// RULE_16: Restart stops switching, cell on at turn-off, off at turn-on.
// RULE_17: Each restart runs soft start, then rechecks faults before normal operation.
// RULE_18: External restart request ignored for 1 ms after start up.
// RULE_19: Comparator flags synchronised; all times counted on one clock.
module bfs_sequencer
    import bfs_pkg::*;
#(
    parameter int QW          = 21,
    parameter int T_SPIKE_CYC = `BFS_CYC(`BFS_T_SPIKE_NS),
    parameter int T_OVPH_CYC  = `BFS_CYC(`BFS_T_OVP_HIGH_NS),
    parameter int T_BLANK_CYC = `BFS_CYC(`BFS_T_BLANK_NS),
    parameter int T_UV_CYC    = `BFS_CYC(`BFS_T_UNDERVOLT_NS),
    parameter int T_EXTW_CYC  = `BFS_CYC(`BFS_T_EXT_BLANK_NS),
    parameter int T_SOFT_CYC  = `BFS_CYC(`BFS_T_SOFT_NS)
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Comparator flags from the analog section.
    input  wire logic       fb_below_entry_i,
    input  wire logic       fb_above_wake_i,
    input  wire logic       fb_below_sleep_i,
    input  wire logic       fb_above_high_i,
    input  wire logic       blank_above_high_i,
    input  wire logic       blank_below_ext_i,
    input  wire logic       vcc_above_soft_ovp_i,
    input  wire logic       vcc_above_ovp_i,
    input  wire logic       vcc_below_uv_i,
    input  wire logic       vcc_at_turn_on_i,
    input  wire logic       vcc_at_turn_off_i,
    input  wire logic       overtemp_i,
    // Power stage control.
    output logic            burst_flag_o,
    output logic            bias_en_o,
    output logic            switching_en_o,
    output logic            reduced_limit_o,
    output logic            startup_cell_en_o,
    output logic            soft_start_o,
    output logic            blank_release_o,
    // Register port.
    input  wire logic [7:0] addr_i,
    input  wire logic [8:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [8:0] rdata_o,
    // Interrupt.
    output logic            irq_o
);

    localparam int NSYNC = 12;
    localparam int NQ    = 10;
    localparam int QMAX  = (1 << QW) - 1;

    if (T_SPIKE_CYC < 1 || T_OVPH_CYC < 1 || T_BLANK_CYC < 1 || T_UV_CYC < 1 ||
        T_EXTW_CYC < 1 || T_SOFT_CYC < 1 || T_SPIKE_CYC > QMAX || T_OVPH_CYC > QMAX ||
        T_BLANK_CYC > QMAX || T_UV_CYC > QMAX || T_EXTW_CYC > QMAX ||
        T_SOFT_CYC > QMAX) begin : g_bad_times
        $error("bfs_sequencer: a time count does not fit the qualifier width");
    end

    function automatic logic [QW-1:0] limit_of(input int idx);
        case (idx)
            Q_OVP_HIGH:  limit_of = QW'(T_OVPH_CYC);
            Q_FB_HIGH:   limit_of = QW'(T_BLANK_CYC);
            Q_BURST:     limit_of = QW'(T_BLANK_CYC);
            Q_UNDERVOLT: limit_of = QW'(T_UV_CYC);
            Q_EXT_WIN:   limit_of = QW'(T_EXTW_CYC);
            Q_SOFT:      limit_of = QW'(T_SOFT_CYC);
            default:     limit_of = QW'(T_SPIKE_CYC);
        endcase
    endfunction : limit_of

    // Two-stage synchronisers for all comparator flags.
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] raw_flags;

    assign raw_flags = {overtemp_i, vcc_at_turn_off_i, vcc_at_turn_on_i, vcc_below_uv_i,
                        vcc_above_ovp_i, vcc_above_soft_ovp_i, blank_below_ext_i,
                        blank_above_high_i, fb_above_high_i, fb_below_sleep_i,
                        fb_above_wake_i, fb_below_entry_i};

    always_ff @(posedge clk_i or negedge rstn_i) begin // see RULE_19
        if (!rstn_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_flags;
            sync_b <= sync_a;
        end
    end

    logic s_fb_low;
    logic s_wake;
    logic s_sleep;
    logic s_fb_high;
    logic s_ba_high;
    logic s_ba_low;
    logic s_ovp_soft;
    logic s_ovp;
    logic s_uv;
    logic s_von;
    logic s_voff;
    logic s_otemp;

    assign {s_otemp, s_voff, s_von, s_uv, s_ovp, s_ovp_soft, s_ba_low, s_ba_high,
            s_fb_high, s_sleep, s_wake, s_fb_low} = sync_b;

    // Persistence timers, one per qualified condition.
    bfs_qual_if q [NQ] ();
    logic [NQ-1:0] q_done;

    for (genvar i = 0; i < NQ; i++) begin : g_qual
        bfs_qualifier #(
            .W     (QW),
            .LIMIT (limit_of(i))
        ) u_qual (
            .clk_i  (clk_i),
            .rstn_i (rstn_i),
            .q      (q[i])
        );
        assign q_done[i] = q[i].done;
    end

    bfs_state_t state;
    logic       burst_bias;
    logic       cell_on;
    logic       powered;
    logic [5:0] fault_vec;
    logic       fault_any;
    logic       ext_armed;

    assign powered   = (state == ST_SOFT) || (state == ST_NORMAL) || (state == ST_BURST);
    assign ext_armed = q_done[Q_EXT_WIN]; // see RULE_18

    // Each fault has its own qualification; only overload passes the extra blanking stage.
    assign q[Q_OVP_SOFT].cond  = s_ovp_soft && s_fb_high && (state == ST_SOFT); // see RULE_09
    assign q[Q_OVP_HIGH].cond  = s_ovp && powered && (state != ST_BURST); // see RULE_10
    assign q[Q_OVERTEMP].cond  = s_otemp && powered; // see RULE_11
    assign q[Q_FB_HIGH].cond   = s_fb_high && ((state == ST_SOFT) || (state == ST_NORMAL));
    assign q[Q_OVERLOAD].cond  = q_done[Q_FB_HIGH] && s_ba_high; // see RULE_12
    assign q[Q_UNDERVOLT].cond = s_uv && powered; // see RULE_13
    assign q[Q_EXT_WIN].cond   = powered;
    assign q[Q_EXT].cond       = s_ba_low && ext_armed; // see RULE_14
    assign q[Q_BURST].cond     = s_fb_low && (state == ST_NORMAL); // see RULE_01
    assign q[Q_SOFT].cond      = (state == ST_SOFT);

    assign fault_vec = q_done[5:0]; // see RULE_15
    assign fault_any = |fault_vec;

    // Operating state.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_CHARGE;
        end else begin
            case (state)
                ST_CHARGE: begin
                    if (s_von) begin
                        state <= ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (fault_any) begin
                        state <= ST_RESTART;
                    end else if (q_done[Q_SOFT]) begin
                        state <= ST_NORMAL; // see RULE_17
                    end
                end
                ST_NORMAL: begin
                    if (fault_any) begin
                        state <= ST_RESTART;
                    end else if (q_done[Q_BURST]) begin
                        state <= ST_BURST; // see RULE_02
                    end
                end
                ST_BURST: begin
                    if (fault_any) begin
                        state <= ST_RESTART;
                    end else if (s_fb_high) begin
                        state <= ST_NORMAL; // see RULE_08
                    end
                end
                ST_RESTART: begin
                    if (cell_on && s_von) begin
                        state <= ST_SOFT; // see RULE_16
                    end
                end
                default: begin
                    state <= ST_CHARGE;
                end
            endcase
        end
    end

    // Bias inside burst mode follows the wake and sleep comparators.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            burst_bias <= 1'b0;
        end else if (state != ST_BURST) begin
            burst_bias <= 1'b0; // see RULE_03
        end else if (s_wake) begin
            burst_bias <= 1'b1; // see RULE_05
        end else if (s_sleep) begin
            burst_bias <= 1'b0; // see RULE_07
        end
    end

    // Startup cell: on from power-on, and in restart once supply reaches turn-off.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cell_on <= 1'b1;
        end else if (cell_on && s_von) begin
            cell_on <= 1'b0; // see RULE_16
        end else if ((state == ST_RESTART) && s_voff) begin
            cell_on <= 1'b1; // see RULE_16
        end
    end

    assign burst_flag_o      = (state == ST_BURST); // see RULE_03
    assign bias_en_o         = powered && ((state != ST_BURST) || burst_bias);
    assign switching_en_o    = bias_en_o && !(s_ba_low && ext_armed);
    assign reduced_limit_o   = (state == ST_BURST) && burst_bias; // see RULE_06
    assign startup_cell_en_o = cell_on && !powered; // see RULE_04
    assign soft_start_o      = (state == ST_SOFT);
    assign blank_release_o   = q_done[Q_FB_HIGH]; // see RULE_12

    // Events, sticky status, mask and interrupt.
    logic [`BFS_EV_WIDTH-1:0] events;
    logic [`BFS_EV_WIDTH-1:0] status;
    logic [`BFS_EV_WIDTH-1:0] mask;
    logic [`BFS_EV_WIDTH-1:0] clr;

    always_comb begin
        events = '0;
        events[`BFS_EV_BURST_IN]  = (state == ST_NORMAL) && q_done[Q_BURST] && !fault_any;
        events[`BFS_EV_BURST_OUT] = (state == ST_BURST) && s_fb_high && !fault_any;
        events[`BFS_EV_SOFT_DONE] = (state == ST_SOFT) && q_done[Q_SOFT] && !fault_any;
        events[`BFS_EV_FAULT_LSB +: 6] = powered ? fault_vec : 6'h00;
    end

    assign clr = (wr_i && (addr_i == `BFS_REG_STATUS)) ? wdata_i : '0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status <= `BFS_STATUS_RST;
        end else begin
            status <= (status & ~clr) | events;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mask <= `BFS_MASK_RST;
        end else if (wr_i && (addr_i == `BFS_REG_MASK)) begin
            mask <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                `BFS_REG_STATUS: rdata_o <= status;
                `BFS_REG_MASK:   rdata_o <= mask;
                `BFS_REG_STATE:  rdata_o <= {1'b0, reduced_limit_o, startup_cell_en_o,
                                             bias_en_o, switching_en_o, burst_flag_o,
                                             state};
                default:         rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    assign irq_o = |(status & mask);

    // Checks.
    logic [QW-1:0] low_run;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_run <= '0;
        end else if (!(s_fb_low && (state == ST_NORMAL))) begin
            low_run <= '0;
        end else if (low_run != QW'(QMAX)) begin
            low_run <= low_run + QW'(1);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_power_up;
        $rose(state == ST_SOFT);
    endsequence

    sequence s_wake_in_burst;
        burst_flag_o && s_wake && !s_fb_high && !fault_any && !(s_ba_low && ext_armed);
    endsequence

    a_burst_blank: assert property ($rose(burst_flag_o) |-> // see RULE_02
        $past(low_run) >= QW'(T_BLANK_CYC))
        else $error("burst entered before the blanking time");
    a_burst_bias_off: assert property ($rose(burst_flag_o) |-> !bias_en_o) // see RULE_03
        else $error("bias still on at burst entry");
    a_cell_in_burst: assert property (burst_flag_o |-> !startup_cell_en_o && !cell_on) // see RULE_04
        else $error("startup cell on during burst");
    a_burst_wake: assert property (s_wake_in_burst |=> bias_en_o && switching_en_o ||
        !burst_flag_o) // see RULE_05
        else $error("bias not resumed on wake");
    a_reduced_limit: assert property (burst_flag_o && bias_en_o |-> reduced_limit_o) // see RULE_06
        else $error("reduced limit not selected in burst");
    a_burst_sleep: assert property (burst_flag_o && s_sleep && !s_wake |=>
        !bias_en_o || !burst_flag_o || $past(s_fb_high)) // see RULE_07
        else $error("bias not switched off on sleep");
    a_burst_exit: assert property (burst_flag_o && s_fb_high && !fault_any |=>
        !burst_flag_o && !reduced_limit_o && bias_en_o) // see RULE_08
        else $error("burst not left on high feedback");
    a_ovp_burst: assert property (burst_flag_o |-> !q[Q_OVP_HIGH].cond) // see RULE_10
        else $error("high supply check active in burst");
    a_restart_quiet: assert property (state == ST_RESTART |-> !switching_en_o) // see RULE_16
        else $error("switching during restart");
    a_ext_window: assert property (s_power_up |-> !ext_armed [*8]) // see RULE_18
        else $error("external restart armed too early");
    a_soft_recheck: assert property (state == ST_SOFT && q_done[Q_SOFT] |=>
        (state == ST_NORMAL) != $past(fault_any)) // see RULE_17
        else $error("soft start end did not recheck faults");

endmodule : bfs_sequencer

`default_nettype wire

/* File: testbench/bfs_analog_model.sv */
`default_nettype none

// Comparators of the converter: the bench sets pin and supply levels in millivolts.
// Every flag is a plain level, so the sequencer must synchronise it itself.
module bfs_analog_model #(
    parameter logic [15:0] ON_MV  = 16'h4650,
    parameter logic [15:0] OFF_MV = 16'h2328
) (
    // Levels from the bench.
    input  wire logic [15:0] fb_i,
    input  wire logic [15:0] ba_i,
    input  wire logic [15:0] vcc_i,
    input  wire logic        hot_i,
    // Comparator flags.
    output logic      [11:0] flag_o
);
    timeunit 1ns;
    timeprecision 1ps;

    assign flag_o[0]  = fb_i < 16'h0546;
    assign flag_o[1]  = fb_i > 16'h0dac;
    assign flag_o[2]  = fb_i <= 16'h0bb8;
    assign flag_o[3]  = fb_i > 16'h0fa0;
    assign flag_o[4]  = ba_i > 16'h0fa0;
    assign flag_o[5]  = ba_i < 16'h014a;
    assign flag_o[6]  = vcc_i > 16'h5014;
    assign flag_o[7]  = vcc_i > 16'h639c;
    assign flag_o[8]  = vcc_i < 16'h2904;
    assign flag_o[9]  = vcc_i >= ON_MV;
    assign flag_o[10] = vcc_i <= OFF_MV;
    assign flag_o[11] = hot_i;
endmodule : bfs_analog_model

`default_nettype wire

/* File: testbench/test_burst_and_fault_sequencer.sv */
`default_nettype none
`include "bfs_params.svh"

module test_burst_and_fault_sequencer
    import bfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TS = 4;
    localparam int TO = 6;
    localparam int TB = 20;
    localparam int TU = 10;
    localparam int TE = 12;
    localparam int TSO = 30;

    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [15:0] fb = 16'h07d0;
    logic [15:0] ba = 16'h07d0;
    logic [15:0] vcc = 16'h2ee0;
    logic        hot = 1'b0;
    logic [11:0] fl;
    logic [7:0]  addr_i = 8'h00;
    logic [8:0]  wdata_i = 9'h000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [8:0]  rdata_o;
    logic        irq_o, burst_o, bias_o, sw_o, red_o, cell_o, soft_o, rel_o;
    int          n_mismatch = 0;
    int          checked = 0;

    always #10 clk_i = ~clk_i;

    bfs_analog_model model (.fb_i(fb), .ba_i(ba), .vcc_i(vcc), .hot_i(hot), .flag_o(fl));

    bfs_sequencer #(
        .T_SPIKE_CYC(TS), .T_OVPH_CYC(TO), .T_BLANK_CYC(TB),
        .T_UV_CYC(TU), .T_EXTW_CYC(TE), .T_SOFT_CYC(TSO)
    ) dut (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .fb_below_entry_i(fl[0]), .fb_above_wake_i(fl[1]), .fb_below_sleep_i(fl[2]),
        .fb_above_high_i(fl[3]), .blank_above_high_i(fl[4]), .blank_below_ext_i(fl[5]),
        .vcc_above_soft_ovp_i(fl[6]), .vcc_above_ovp_i(fl[7]), .vcc_below_uv_i(fl[8]),
        .vcc_at_turn_on_i(fl[9]), .vcc_at_turn_off_i(fl[10]), .overtemp_i(fl[11]),
        .burst_flag_o(burst_o), .bias_en_o(bias_o), .switching_en_o(sw_o),
        .reduced_limit_o(red_o), .startup_cell_en_o(cell_o), .soft_start_o(soft_o),
        .blank_release_o(rel_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o)
    );

    task automatic close_out();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask : hold

    task automatic reg_wr(input logic [7:0] a, input logic [8:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [8:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    task automatic rd_chk(input logic [7:0] a, input logic [8:0] exp, input string what);
        logic [8:0] d;
        reg_rd(a, d);
        chk(d, exp, what);
    endtask : rd_chk

    // Polls the state word; gives up and ends the run when the bound is used up.
    task automatic wait_st(input bfs_state_t s, input int lim);
        logic [8:0] d;
        for (int i = 0; i < lim; i++) begin
            reg_rd(`BFS_REG_STATE, d);
            if (d[2:0] === s) return;
        end
        n_mismatch++;
        $display("unexpected at %0t: state %0d not reached", $time, s);
        close_out();
    endtask : wait_st

    task automatic t_reset();
        chk({1'b0, cell_o, burst_o, bias_o, sw_o, red_o, soft_o, rel_o, irq_o}, 9'h080,
            "reset outputs");
        @(posedge clk_i);
        rstn_i <= 1'b1;
        rd_chk(`BFS_REG_STATE, 9'h040, "state");
        rd_chk(`BFS_REG_STATUS, `BFS_STATUS_RST, "status");
        rd_chk(`BFS_REG_MASK, `BFS_MASK_RST, "mask");
        reg_wr(8'h0c, 9'h1ff);
        rd_chk(8'h0c, 9'h000, "unmapped");
        reg_wr(`BFS_REG_STATE, 9'h1ff);
        rd_chk(`BFS_REG_STATE, 9'h040, "state read only");
        reg_wr(`BFS_REG_MASK, 9'h1ff);
        rd_chk(`BFS_REG_MASK, 9'h1ff, "mask rw");
        reg_wr(`BFS_REG_MASK, 9'h000);
        $display("test reset done");
    endtask : t_reset

    // Power-on through soft start; an early external request must not count.
    task automatic t_power();
        vcc <= 16'h4a38;
        wait_st(ST_SOFT, 10);
        rd_chk(`BFS_REG_STATE, 9'h031, "soft word");
        chk({8'h00, soft_o}, 9'h001, "soft pin");
        vcc <= 16'h3a98;
        ba  <= 16'h00c8;
        hold(TE - 8);
        ba <= 16'h07d0;
        rd_chk(`BFS_REG_STATE, 9'h031, "ext ignored early");
        wait_st(ST_NORMAL, TSO);
        rd_chk(`BFS_REG_STATE, 9'h032, "normal word");
        rd_chk(`BFS_REG_STATUS, 9'h004, "soft done event");
        reg_wr(`BFS_REG_STATUS, 9'h1ff);
        $display("test power done");
    endtask : t_power

    task automatic t_burst();
        fb <= 16'h03e8;
        hold(TB - 6);
        fb <= 16'h07d0;
        hold(4);
        fb <= 16'h03e8;
        hold(TB - 4);
        rd_chk(`BFS_REG_STATE, 9'h032, "blank restarted");
        wait_st(ST_BURST, 10);
        rd_chk(`BFS_REG_STATE, 9'h00b, "burst asleep");
        vcc <= 16'h6590;
        hold(TO + 6);
        vcc <= 16'h3a98;
        rd_chk(`BFS_REG_STATE, 9'h00b, "ovp off in burst");
        fb <= 16'h0e10;
        hold(5);
        rd_chk(`BFS_REG_STATE, 9'h0bb, "burst awake");
        chk({5'h00, burst_o, bias_o, sw_o, red_o}, 9'h00f, "burst pins");
        fb <= 16'h0b54;
        hold(5);
        rd_chk(`BFS_REG_STATE, 9'h00b, "burst sleep");
        fb <= 16'h1004;
        hold(5);
        fb <= 16'h07d0;
        rd_chk(`BFS_REG_STATE, 9'h032, "burst left");
        rd_chk(`BFS_REG_STATUS, 9'h003, "burst events");
        reg_wr(`BFS_REG_MASK, 9'h001);
        hold(1);
        chk({8'h00, irq_o}, 9'h001, "irq raised");
        reg_wr(`BFS_REG_MASK, 9'h000);
        hold(1);
        chk({8'h00, irq_o}, 9'h000, "irq masked");
        reg_wr(`BFS_REG_MASK, 9'h002);
        reg_wr(`BFS_REG_STATUS, 9'h002);
        hold(1);
        chk({8'h00, irq_o}, 9'h000, "irq cleared");
        rd_chk(`BFS_REG_STATUS, 9'h001, "w1c");
        reg_wr(`BFS_REG_STATUS, 9'h1ff);
        reg_wr(`BFS_REG_MASK, 9'h000);
        $display("test burst done");
    endtask : t_burst

    // Supply cycle of auto restart: cell on at turn-off, off again at turn-on.
    task automatic recover(input bit persist);
        rd_chk(`BFS_REG_STATE, 9'h004, "restart word");
        vcc <= 16'h2328;
        hold(4);
        rd_chk(`BFS_REG_STATE, 9'h044, "cell on");
        vcc <= 16'h4a38;
        wait_st(ST_SOFT, 10);
        rd_chk(`BFS_REG_STATE, 9'h031, "cell off");
        vcc <= 16'h3a98;
        wait_st(persist ? ST_RESTART : ST_NORMAL, TSO);
        reg_wr(`BFS_REG_STATUS, 9'h1ff);
    endtask : recover

    task automatic t_fault(input int k);
        int t;
        t = TS;
        case (k)
            1: begin
                vcc <= 16'h6590;
                t = TO;
            end
            2: hot <= 1'b1;
            3: begin
                fb <= 16'h1004;
                hold(TB - 2);
                chk({8'h00, rel_o}, 9'h000, "release early");
                for (int i = 0; i < 20 && rel_o !== 1'b1; i++) @(posedge clk_i);
                chk({8'h00, rel_o}, 9'h001, "release set");
                ba <= 16'h1004;
            end
            4: begin
                vcc <= 16'h2710;
                t = TU;
            end
            default: ba <= 16'h00c8;
        endcase
        hold(t - 1);
        // An armed external request stops switching before it has qualified.
        rd_chk(`BFS_REG_STATE, (k == 5) ? 9'h022 : 9'h032, "fault early");
        wait_st(ST_RESTART, 8);
        rd_chk(`BFS_REG_STATUS, 9'h001 << (`BFS_EV_FAULT_LSB + k), "fault event");
        fb <= 16'h07d0;
        ba <= 16'h07d0;
        if (k == 2) begin
            recover(1'b1);
            hot <= 1'b0;
        end
        recover(1'b0);
        $display("test fault %0d done", k);
    endtask : t_fault

    // A reset in mid-run, then supply and feedback high inside soft start.
    task automatic t_ovp_soft();
        rstn_i <= 1'b0;
        vcc    <= 16'h2ee0;
        hold(2);
        rstn_i <= 1'b1;
        vcc    <= 16'h4a38;
        wait_st(ST_SOFT, 10);
        vcc <= 16'h5208;
        fb  <= 16'h1004;
        hold(TS - 1);
        rd_chk(`BFS_REG_STATE, 9'h031, "soft ovp early");
        wait_st(ST_RESTART, 8);
        rd_chk(`BFS_REG_STATUS, 9'h008, "soft ovp event");
        fb <= 16'h07d0;
        recover(1'b0);
        $display("test soft ovp done");
    endtask : t_ovp_soft

    initial begin
        hold(20);
        t_reset();
        t_power();
        t_burst();
        for (int k = 1; k < 6; k++) t_fault(k);
        t_ovp_soft();
        close_out();
    end
endmodule : test_burst_and_fault_sequencer

`default_nettype wire
